// >>> inc/brdreg_pkg.sv
// Package of constants, types and decode helpers for the board register bank.
package brdreg_pkg;

	// ----------------------------------------------------------------
	// Bus geometry and register offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;

	// ----------------------------------------------------------------
	// Control register field positions
	// ----------------------------------------------------------------
	localparam int CTL_SUPPLY_LO = 9;
	localparam int CTL_VPP_LO = 10;
	localparam int CTL_VPP_HI = 11;
	localparam int CTL_DRAM_HALF = 12;
	localparam int CTL_XCVR2_N = 13;
	localparam int CTL_SDRAM_EN = 14;
	localparam int CTL_SUPPLY_HI = 15;

	// ----------------------------------------------------------------
	// Status register field positions
	// ----------------------------------------------------------------
	localparam int ST_FLASH_LO = 0;
	localparam int ST_FLASH_HI = 3;
	localparam int ST_DRAM_LO = 5;
	localparam int ST_DRAM_HI = 8;
	localparam int ST_TOOL_LO = 9;
	localparam int ST_TOOL_HI = 12;
	localparam int ST_REV_LO = 13;
	localparam int ST_REV_HI = 15;
	localparam int DET_W = 4;
	localparam int REV_W = 3;

	// ----------------------------------------------------------------
	// Power-on values and encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] VPP_RST = 2'h3;
	localparam logic SUPPLY_LO_RST = 1'b0;
	localparam logic SUPPLY_HI_RST = 1'b0;
	localparam logic DRAM_HALF_RST = 1'b1;
	localparam logic XCVR2_N_RST = 1'b1;
	localparam logic SDRAM_EN_RST = 1'b1;
	localparam logic [1:0] VPP_0V = 2'h0;
	localparam logic [1:0] VPP_5V = 2'h1;
	localparam logic [1:0] VPP_12V = 2'h2;
	localparam logic [1:0] VPP_HIZ = 2'h3;
	localparam logic [1:0] VCC_5V = 2'h1;
	localparam logic [1:0] VCC_3V3 = 2'h2;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

	// Control register contents kept by the bank.
	typedef struct packed {
		logic [1:0] vppSel;
		logic supplyHi;
		logic supplyLo;
		logic dramHalf;
		logic xcvr2En_n;
		logic sync_dram_en;
	} brdreg_ctrl_s;

	// Tells whether an address selects a given register.
	function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
			input logic [ADDR_W-1:0] off);
		addrHit = (addr == off);
	endfunction

endpackage

// >>> inc/brdreg_if.sv
// Interface carrying the synchronised detect lines between modules.
`timescale 1ns/1ps
interface brdreg_if;
	logic [brdreg_pkg::DET_W-1:0] flashDet;
	logic [brdreg_pkg::DET_W-1:0] dramDet;
	logic [brdreg_pkg::DET_W-1:0] toolId;

	modport src (
		output flashDet,
		output dramDet,
		output toolId
	);
	modport dst (
		input flashDet,
		input dramDet,
		input toolId
	);
endinterface

// >>> hdl/brdreg_sync.sv
// Two-stage synchroniser for the board detect and tool ident lines.
`timescale 1ns/1ps
module brdreg_sync (
	input wire logic ref_clk,
	input wire logic rstSync_n,
	input wire logic [brdreg_pkg::DET_W-1:0] flashRaw,
	input wire logic [brdreg_pkg::DET_W-1:0] dramRaw,
	input wire logic [brdreg_pkg::DET_W-1:0] toolRaw,
	brdreg_if.src det
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3*brdreg_pkg::DET_W-1:0] meta;
		logic [3*brdreg_pkg::DET_W-1:0] sync;
	} brdreg_sync_s;

	brdreg_sync_s state_r;
	brdreg_sync_s state_nxt;

	// The first stage only feeds the second stage.
	always_comb begin
		state_nxt = state_r;
		state_nxt.meta = {flashRaw, dramRaw, toolRaw};
		state_nxt.sync = state_r.meta;
	end

	// Registers the synchroniser stages.
	always_ff @(posedge ref_clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Splits the second stage back into its three groups.
	assign det.flashDet = state_r.sync[3*brdreg_pkg::DET_W-1:
		2*brdreg_pkg::DET_W];
	assign det.dramDet = state_r.sync[2*brdreg_pkg::DET_W-1:
		brdreg_pkg::DET_W];
	assign det.toolId = state_r.sync[brdreg_pkg::DET_W-1:0];

endmodule // brdreg_sync

// >>> hdl/brdreg_top.sv
// Board control and status register bank with its decoded outputs.
`timescale 1ns/1ps
module brdreg_top #(
	parameter logic [brdreg_pkg::REV_W-1:0] DAUGHTER_REV = 3'h0
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [brdreg_pkg::ADDR_W-1:0] regAddr,
	input wire logic [brdreg_pkg::DATA_W-1:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [brdreg_pkg::DATA_W-1:0] regRdData,
	input wire logic bankEnable,
	input wire logic dramHalfStepsDone,
	input wire logic [brdreg_pkg::DET_W-1:0] flashModuleTypeDetect,
	input wire logic [brdreg_pkg::DET_W-1:0] dramModuleDetect,
	input wire logic [brdreg_pkg::DET_W-1:0] extToolIdent,
	output logic [1:0] cardProgVoltageSel,
	output logic vppDriveEn,
	output logic vpp5vOn,
	output logic vpp12vOn,
	output logic cardSupplySelHi,
	output logic cardSupplySelLo,
	output logic vcc5vOn,
	output logic vcc3v3On,
	output logic dramWidth16,
	output logic serialXcvr2En_n,
	output logic serialXcvr2Standby,
	output logic syncDramEn,
	output logic dramLowPower,
	output logic dramMapped,
	output logic dramCsFree
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rstMeta_r;
	logic rstSync_r;

	// Releases the reset through two flip-flops, asserts it at once.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	// ----------------------------------------------------------------
	// Detect line synchroniser
	// ----------------------------------------------------------------
	brdreg_if det ();

	brdreg_sync u_sync (
		.ref_clk(ref_clk),
		.rstSync_n(rstSync_r),
		.flashRaw(flashModuleTypeDetect),
		.dramRaw(dramModuleDetect),
		.toolRaw(extToolIdent),
		.det(det.src)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		brdreg_pkg::brdreg_ctrl_s ctrl;
		logic [brdreg_pkg::DATA_W-1:0] rdData;
	} brdreg_state_s;

	brdreg_state_s state_r;
	brdreg_state_s state_nxt;
	logic ctrlHit;
	logic statusHit;
	logic [brdreg_pkg::DATA_W-1:0] ctrlWord;
	logic [brdreg_pkg::DATA_W-1:0] statusWord;

	// Decodes the two registers; a disabled bank answers nothing.
	assign ctrlHit = bankEnable &&
		brdreg_pkg::addrHit(regAddr, brdreg_pkg::OFF_CTRL);
	assign statusHit = bankEnable &&
		brdreg_pkg::addrHit(regAddr, brdreg_pkg::OFF_STATUS);

	// Assembles the control word; bits outside the fields stay zero.
	always_comb begin
		ctrlWord = brdreg_pkg::ZERO_WORD;
		ctrlWord[brdreg_pkg::CTL_SUPPLY_LO] = state_r.ctrl.supplyLo;
		ctrlWord[brdreg_pkg::CTL_VPP_HI:brdreg_pkg::CTL_VPP_LO] =
			state_r.ctrl.vppSel;
		ctrlWord[brdreg_pkg::CTL_DRAM_HALF] = state_r.ctrl.dramHalf;
		ctrlWord[brdreg_pkg::CTL_XCVR2_N] = state_r.ctrl.xcvr2En_n;
		ctrlWord[brdreg_pkg::CTL_SDRAM_EN] = state_r.ctrl.sync_dram_en;
		ctrlWord[brdreg_pkg::CTL_SUPPLY_HI] = state_r.ctrl.supplyHi;
	end

	// Assembles the status word from the live synchronised lines.
	always_comb begin
		statusWord = brdreg_pkg::ZERO_WORD;
		statusWord[brdreg_pkg::ST_FLASH_HI:brdreg_pkg::ST_FLASH_LO] =
			det.flashDet;
		statusWord[brdreg_pkg::ST_DRAM_HI:brdreg_pkg::ST_DRAM_LO] =
			det.dramDet;
		statusWord[brdreg_pkg::ST_TOOL_HI:brdreg_pkg::ST_TOOL_LO] =
			det.toolId;
		statusWord[brdreg_pkg::ST_REV_HI:brdreg_pkg::ST_REV_LO] =
			DAUGHTER_REV;
	end

	// Next state: writes update control, reads load the answer word.
	always_comb begin
		state_nxt = state_r;
		state_nxt.rdData = brdreg_pkg::ZERO_WORD;
		if (regWrStb && ctrlHit) begin
			state_nxt.ctrl.supplyLo =
				regWrData[brdreg_pkg::CTL_SUPPLY_LO];
			state_nxt.ctrl.vppSel = regWrData[brdreg_pkg::CTL_VPP_HI:
				brdreg_pkg::CTL_VPP_LO];
			state_nxt.ctrl.dramHalf =
				regWrData[brdreg_pkg::CTL_DRAM_HALF];
			state_nxt.ctrl.xcvr2En_n =
				regWrData[brdreg_pkg::CTL_XCVR2_N];
			state_nxt.ctrl.sync_dram_en =
				regWrData[brdreg_pkg::CTL_SDRAM_EN];
			state_nxt.ctrl.supplyHi =
				regWrData[brdreg_pkg::CTL_SUPPLY_HI];
		end
		if (regRdStb) begin
			if (ctrlHit) begin
				state_nxt.rdData = ctrlWord;
			end else if (statusHit) begin
				state_nxt.rdData = statusWord;
			end else begin
				state_nxt.rdData = brdreg_pkg::ZERO_WORD;
			end
		end
	end

	// Registers the whole state; power-on values come from the package.
	always_ff @(posedge ref_clk or negedge rstSync_r) begin
		if (!rstSync_r) begin
			state_r.ctrl.vppSel <= brdreg_pkg::VPP_RST;
			state_r.ctrl.supplyHi <= brdreg_pkg::SUPPLY_HI_RST;
			state_r.ctrl.supplyLo <= brdreg_pkg::SUPPLY_LO_RST;
			state_r.ctrl.dramHalf <= brdreg_pkg::DRAM_HALF_RST;
			state_r.ctrl.xcvr2En_n <= brdreg_pkg::XCVR2_N_RST;
			state_r.ctrl.sync_dram_en <= brdreg_pkg::SDRAM_EN_RST;
			state_r.rdData <= brdreg_pkg::ZERO_WORD;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Decoded board controls
	// ----------------------------------------------------------------
	logic [1:0] vccCode;

	// Drives the card supplies from the select fields.
	assign vccCode = {state_r.ctrl.supplyHi, state_r.ctrl.supplyLo};
	assign cardProgVoltageSel = state_r.ctrl.vppSel;
	assign vppDriveEn = (state_r.ctrl.vppSel != brdreg_pkg::VPP_HIZ);
	assign vpp5vOn = (state_r.ctrl.vppSel == brdreg_pkg::VPP_5V);
	assign vpp12vOn = (state_r.ctrl.vppSel == brdreg_pkg::VPP_12V);
	assign cardSupplySelHi = state_r.ctrl.supplyHi;
	assign cardSupplySelLo = state_r.ctrl.supplyLo;
	assign vcc5vOn = (vccCode == brdreg_pkg::VCC_5V);
	assign vcc3v3On = (vccCode == brdreg_pkg::VCC_3V3);

	// Memory, serial port and DRAM map controls.
	assign dramWidth16 = !state_r.ctrl.dramHalf && dramHalfStepsDone;
	assign serialXcvr2En_n = state_r.ctrl.xcvr2En_n;
	assign serialXcvr2Standby = state_r.ctrl.xcvr2En_n;
	assign syncDramEn = state_r.ctrl.sync_dram_en;
	assign dramMapped = state_r.ctrl.sync_dram_en;
	assign dramLowPower = !state_r.ctrl.sync_dram_en;
	assign dramCsFree = !state_r.ctrl.sync_dram_en;
	assign regRdData = state_r.rdData;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstSync_r);

	logic ctrlWrite;
	logic ctrlRead;
	logic statusRead;
	logic [brdreg_pkg::DET_W-1:0] flashSeen;
	logic [brdreg_pkg::DET_W-1:0] dramSeen;

	// Helper terms that only the checks read.
	assign ctrlWrite = regWrStb && ctrlHit;
	assign ctrlRead = regRdStb && ctrlHit;
	assign statusRead = regRdStb && statusHit;
	assign flashSeen = regRdData[brdreg_pkg::ST_FLASH_HI:
		brdreg_pkg::ST_FLASH_LO];
	assign dramSeen = regRdData[brdreg_pkg::ST_DRAM_HI:
		brdreg_pkg::ST_DRAM_LO];

	logic [1:0] wrVpp;
	logic [1:0] wrSupply;
	logic [brdreg_pkg::CTL_SUPPLY_HI-brdreg_pkg::CTL_SUPPLY_LO:0] wrCtrl;
	logic [brdreg_pkg::CTL_SUPPLY_HI-brdreg_pkg::CTL_SUPPLY_LO:0] ctrlSeen;

	// Write-data and read-data fields that the checks compare.
	assign wrVpp = regWrData[brdreg_pkg::CTL_VPP_HI:
		brdreg_pkg::CTL_VPP_LO];
	assign wrSupply = {regWrData[brdreg_pkg::CTL_SUPPLY_HI],
		regWrData[brdreg_pkg::CTL_SUPPLY_LO]};
	assign wrCtrl = regWrData[brdreg_pkg::CTL_SUPPLY_HI:
		brdreg_pkg::CTL_SUPPLY_LO];
	assign ctrlSeen = regRdData[brdreg_pkg::CTL_SUPPLY_HI:
		brdreg_pkg::CTL_SUPPLY_LO];

	a_vpp_write: assert property (
		ctrlWrite |=> cardProgVoltageSel == $past(wrVpp))
		else $error("Programming voltage select did not take the write.");

	a_vpp_hiz_off: assert property (
		cardProgVoltageSel == brdreg_pkg::VPP_HIZ |->
			!vppDriveEn && !vpp5vOn && !vpp12vOn)
		else $error("Programming voltage drives while high-Z is chosen.");

	a_vpp_levels: assert property (
		ctrlWrite |=> vpp5vOn == ($past(wrVpp) == brdreg_pkg::VPP_5V) &&
			vpp12vOn == ($past(wrVpp) == brdreg_pkg::VPP_12V) &&
			vppDriveEn == ($past(wrVpp) != brdreg_pkg::VPP_HIZ))
		else $error("Programming voltage outputs do not match the code.");

	a_vcc_decode: assert property (
		ctrlWrite && wrSupply == brdreg_pkg::VCC_3V3 |=>
			vcc3v3On && !vcc5vOn)
		else $error("Supply select 10 did not give 3.3 V.");

	a_vcc_five: assert property (
		ctrlWrite && wrSupply == brdreg_pkg::VCC_5V |=>
			vcc5vOn && !vcc3v3On)
		else $error("Supply select 01 did not give 5 V.");

	a_vcc_off: assert property (
		ctrlWrite && wrSupply[1] == wrSupply[0] |=>
			!vcc5vOn && !vcc3v3On)
		else $error("Supply select 00 or 11 left a supply on.");

	a_dram_width: assert property (
		ctrlWrite |=> dramWidth16 ==
			(!$past(regWrData[brdreg_pkg::CTL_DRAM_HALF]) &&
			dramHalfStepsDone))
		else $error("DRAM width does not follow bit 12 and the steps.");

	a_xcvr_standby: assert property (
		ctrlWrite && regWrData[brdreg_pkg::CTL_XCVR2_N] |=>
			serialXcvr2Standby && serialXcvr2En_n)
		else $error("Serial port 2 left standby after disable write.");

	a_xcvr_enable: assert property (
		ctrlWrite && !regWrData[brdreg_pkg::CTL_XCVR2_N] |=>
			!serialXcvr2Standby && !serialXcvr2En_n)
		else $error("Serial port 2 stayed in standby after enable write.");

	a_sdram_on: assert property (
		ctrlWrite && regWrData[brdreg_pkg::CTL_SDRAM_EN] |=>
			dramMapped && syncDramEn && !dramLowPower && !dramCsFree)
		else $error("DRAM left the map although its enable was set.");

	a_sdram_off: assert property (
		ctrlWrite && !regWrData[brdreg_pkg::CTL_SDRAM_EN] |=>
			!dramMapped && dramLowPower && dramCsFree && !syncDramEn)
		else $error("DRAM stayed mapped after its enable was cleared.");

	a_status_flash: assert property (
		statusRead |=> flashSeen == $past(det.flashDet))
		else $error("Status read did not show the flash detect lines.");

	a_status_dram: assert property (
		statusRead |=> dramSeen == $past(det.dramDet) &&
			!regRdData[brdreg_pkg::ST_DRAM_LO-1])
		else $error("Status read showed wrong DRAM detect or bit 4.");

	a_status_rev: assert property (
		statusRead |=> regRdData[brdreg_pkg::ST_REV_HI:
			brdreg_pkg::ST_REV_LO] == DAUGHTER_REV &&
			regRdData[brdreg_pkg::ST_TOOL_HI:brdreg_pkg::ST_TOOL_LO] ==
			$past(det.toolId))
		else $error("Status read showed wrong tool ident or revision.");

	a_bank_off: assert property (
		regRdStb && !bankEnable |=> regRdData == brdreg_pkg::ZERO_WORD)
		else $error("A disabled bank answered a read.");

	a_ctrl_upper: assert property (
		ctrlRead |=>
			regRdData[brdreg_pkg::DATA_W-1:brdreg_pkg::CTL_SUPPLY_HI+1] ==
			'0 && regRdData[brdreg_pkg::CTL_SUPPLY_LO-1:0] == '0)
		else $error("Unimplemented control bits read as non-zero.");

	a_ctrl_readback: assert property (
		ctrlWrite ##1 !ctrlWrite ##1 ctrlRead |=>
			ctrlSeen == $past(wrCtrl, 3))
		else $error("Control read did not return the word last written.");

	a_status_nowr: assert property (
		regWrStb && !ctrlHit |=> $stable(state_r.ctrl))
		else $error("A write outside the control register changed it.");

	a_rd_one_cycle: assert property (
		!regRdStb |=> regRdData == brdreg_pkg::ZERO_WORD)
		else $error("Read data stood outside the answer cycle.");

	c_ctrl_rw: cover property (ctrlWrite ##2 ctrlRead);
	c_status_rd: cover property ((regWrStb && statusHit) ##2 statusRead);
	c_sdram_off: cover property (
		ctrlWrite && !regWrData[brdreg_pkg::CTL_SDRAM_EN]);
	c_bank_off: cover property (regRdStb && !bankEnable);
	c_dram_half: cover property (dramWidth16);

endmodule // brdreg_top

// >>> testbench/brdreg_host.sv
// Host bus master model that drives the register bank's local bus.
`timescale 1ns/1ps
module brdreg_host (
	input wire logic ref_clk,
	output logic [brdreg_pkg::ADDR_W-1:0] regAddr,
	output logic [brdreg_pkg::DATA_W-1:0] regWrData,
	output logic regWrStb,
	output logic regRdStb,
	input wire logic [brdreg_pkg::DATA_W-1:0] regRdData
);
	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	// The bus starts idle, with no strobe raised.
	initial begin
		regAddr = 8'h00;
		regWrData = 32'h0000_0000;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
	end

	// One write cycle; released lines show the inverse so stale values
	// cannot be mistaken for a request.
	task automatic busWrite(input logic [brdreg_pkg::ADDR_W-1:0] addr,
			input logic [brdreg_pkg::DATA_W-1:0] data);
		@(posedge ref_clk);
		regAddr <= addr;
		regWrData <= data;
		regWrStb <= 1'b1;
		@(posedge ref_clk);
		regWrStb <= 1'b0;
		regAddr <= ~addr;
		regWrData <= ~data;
		#1;
	endtask

	// One read cycle; the answer is taken in the cycle after the strobe.
	task automatic busRead(input logic [brdreg_pkg::ADDR_W-1:0] addr,
			output logic [brdreg_pkg::DATA_W-1:0] data);
		@(posedge ref_clk);
		regAddr <= addr;
		regRdStb <= 1'b1;
		@(posedge ref_clk);
		regRdStb <= 1'b0;
		regAddr <= ~addr;
		#1;
		data = regRdData;
	endtask
endmodule // brdreg_host

// >>> testbench/tb.sv
// Self-checking testbench for the board register bank.
`timescale 1ns/1ps
module tb;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	// Arbitrary revision code strapped for this bench.
	localparam logic [brdreg_pkg::REV_W-1:0] REV = 3'h5;
	logic ref_clk;
	logic rst_n;
	logic [brdreg_pkg::ADDR_W-1:0] regAddr;
	logic [brdreg_pkg::DATA_W-1:0] regWrData;
	logic regWrStb, regRdStb;
	logic [brdreg_pkg::DATA_W-1:0] regRdData;
	logic bankEnable, dramHalfStepsDone;
	logic [3:0] flashModuleTypeDetect, dramModuleDetect, extToolIdent;
	logic [1:0] cardProgVoltageSel;
	logic vppDriveEn, vpp5vOn, vpp12vOn, cardSupplySelHi, cardSupplySelLo;
	logic vcc5vOn, vcc3v3On, dramWidth16, serialXcvr2En_n;
	logic serialXcvr2Standby, syncDramEn, dramLowPower, dramMapped;
	logic dramCsFree;
	logic [15:0] outVec;
	int failCount = 0;
	int checkCount = 0;

	brdreg_top #(.DAUGHTER_REV(REV)) DUT (
		.ref_clk, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb,
		.regRdData, .bankEnable, .dramHalfStepsDone,
		.flashModuleTypeDetect, .dramModuleDetect, .extToolIdent,
		.cardProgVoltageSel, .vppDriveEn, .vpp5vOn, .vpp12vOn,
		.cardSupplySelHi, .cardSupplySelLo, .vcc5vOn, .vcc3v3On,
		.dramWidth16, .serialXcvr2En_n, .serialXcvr2Standby, .syncDramEn,
		.dramLowPower, .dramMapped, .dramCsFree
	);

	brdreg_host host (
		.ref_clk, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData
	);

	// All decoded outputs gathered into one word for comparison.
	assign outVec = {cardProgVoltageSel, vppDriveEn, vpp5vOn, vpp12vOn,
		cardSupplySelHi, cardSupplySelLo, vcc5vOn, vcc3v3On, dramWidth16,
		serialXcvr2En_n, serialXcvr2Standby, syncDramEn, dramLowPower,
		dramMapped, dramCsFree};

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Expected decoded outputs for a control word and the steps input.
	function automatic logic [15:0] expOut(input logic [15:0] c,
			input logic steps);
		logic [1:0] v;
		logic [1:0] s;
		v = c[11:10];
		s = {c[15], c[9]};
		expOut = {v, v != 2'h3, v == 2'h1, v == 2'h2, s, s == 2'h1,
			s == 2'h2, !c[12] && steps, c[13], c[13], c[14], !c[14],
			c[14], !c[14]};
	endfunction

	// Compares a seen value with the expected one and counts the result.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			failCount++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	// Reads a register and compares the answer.
	task automatic rdChk(input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] d;
		host.busRead(addr, d);
		check(d, exp);
	endtask

	// Prints the verdict and ends the run.
	task automatic finish_test;
		if (failCount == 0 && checkCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Free-running 10 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// Cuts a hung run short well beyond the expected run of about 120 cycles.
	initial begin
		repeat (3000) @(posedge ref_clk);
		failCount++;
		finish_test;
	end

	// Main test sequence.
	initial begin
		int i;
		logic [31:0] w;
		logic [31:0] st;
		logic [7:0] bad [3];
		bad = '{8'h00, 8'h0c, 8'h09};
		rst_n = 1'b0;
		bankEnable = 1'b1;
		dramHalfStepsDone = 1'b0;
		flashModuleTypeDetect = 4'h0;
		dramModuleDetect = 4'h0;
		extToolIdent = 4'hf;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		check(32'(outVec), 32'(expOut(16'h7c00, 1'b0)));
		rdChk(brdreg_pkg::OFF_CTRL, 32'h0000_7c00);
		// Sweep every select code and control bit, with junk elsewhere.
		for (i = 0; i < 8; i++) begin
			w = {16'ha5c3, i[1], i[2:0], i[1:0], i[0], 9'h1a5};
			@(posedge ref_clk);
			dramHalfStepsDone <= i[1];
			host.busWrite(brdreg_pkg::OFF_CTRL, w);
			check(32'(outVec), 32'(expOut(w[15:0], i[1])));
			rdChk(brdreg_pkg::OFF_CTRL, w & 32'h0000_fe00);
		end
		// Status follows the detect pins; writes to it are dropped.
		for (i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			flashModuleTypeDetect <= 4'(i + 4);
			dramModuleDetect <= {1'b1, i[0], i[1], !i[0]};
			extToolIdent <= 4'(8 + 2 * i);
			repeat (3) @(posedge ref_clk);
			host.busWrite(brdreg_pkg::OFF_STATUS, 32'hffff_ffff);
			st = {16'h0000, REV, 4'(8 + 2 * i), 1'b1, i[0], i[1], !i[0],
				1'b0, 4'(i + 4)};
			rdChk(brdreg_pkg::OFF_STATUS, st);
		end
		rdChk(brdreg_pkg::OFF_CTRL, 32'h0000_fe00);
		// A disabled bank answers zero and ignores writes.
		@(posedge ref_clk);
		bankEnable <= 1'b0;
		host.busWrite(brdreg_pkg::OFF_CTRL, 32'h0000_0000);
		rdChk(brdreg_pkg::OFF_CTRL, 32'h0000_0000);
		rdChk(brdreg_pkg::OFF_STATUS, 32'h0000_0000);
		check(32'(outVec), 32'(expOut(16'hfe00, 1'b1)));
		@(posedge ref_clk);
		bankEnable <= 1'b1;
		rdChk(brdreg_pkg::OFF_CTRL, 32'h0000_fe00);
		// Unmapped addresses read zero and leave the control word alone.
		for (i = 0; i < 3; i++) begin
			host.busWrite(bad[i], 32'h0000_0000);
			rdChk(bad[i], 32'h0000_0000);
		end
		rdChk(brdreg_pkg::OFF_CTRL, 32'h0000_fe00);
		@(posedge ref_clk);
		#1;
		check(regRdData, 32'h0000_0000);
		// A second reset in mid-run restores the power-on values.
		@(posedge ref_clk);
		rst_n <= 1'b0;
		@(posedge ref_clk);
		#1;
		check(32'(outVec), 32'(expOut(16'h7c00, 1'b1)));
		@(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rdChk(brdreg_pkg::OFF_CTRL, 32'h0000_7c00);
		finish_test;
	end
endmodule // tb
